// [logic/dmsd_defines.vh]
// Constants for the data memory space decoder
`ifndef DMSD_DEFINES_VH
`define DMSD_DEFINES_VH
`define DMSD_AUX_CTRL_ADDR 8'h8E
`define DMSD_SECOND_AUX_ADDR 8'hA2
`define DMSD_PTR0_LOW_ADDR 8'h82
`define DMSD_PTR0_HIGH_ADDR 8'h83
`define DMSD_PTR1_LOW_ADDR 8'h84
`define DMSD_PTR1_HIGH_ADDR 8'h85
`define DMSD_OFFCHIP_BIT 1
`define DMSD_SUPPRESS_BIT 0
`define DMSD_SELECTOR_BIT 0
`define DMSD_AUX_RESET 2'h0
`define DMSD_LOWER_TOP 8'h7F
`define DMSD_EXPANDED_ONCHIP_RAM_TOP 16'h01FF
`define DMSD_STROBE_DIV 3'h6
`define DMSD_EXPANDED_ONCHIP_RAM_DEPTH 512
`define DMSD_EXPANDED_ONCHIP_RAM_AW 9
`endif

// [logic/dmsd_latch_strobe.v]
// Address-latch strobe generator, free-running or access-only
`timescale 1ns/10ps
`default_nettype none
`include "dmsd_defines.vh"
module dmsd_latch_strobe (
  input wire clk_in,
  input wire rst_n_in,
  input wire suppress_in,
  input wire ext_cycle_in,
  output reg strobe_out
);
  reg [2:0] div_ff;
  reg [2:0] nxt_div;
  reg nxt_strobe;

  // Divide the core clock by six; one high cycle per period
  always @* begin
    if (div_ff == `DMSD_STROBE_DIV - 3'h1) begin
      nxt_div = 3'h0;
    end else begin
      nxt_div = div_ff + 3'h1;
    end
    if (suppress_in) begin
      nxt_strobe = ext_cycle_in;
    end else begin
      nxt_strobe = (div_ff == 3'h0);
    end
  end

  // Strobe registered so the pin never glitches
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_ff <= 3'h0;
      strobe_out <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      strobe_out <= nxt_strobe;
    end
  end
endmodule
`default_nettype wire

// [logic/dmsd_core.v]
// Data memory space decoder: internal RAM, special space, expanded RAM, external bus
`timescale 1ns/10ps
`default_nettype none
`include "dmsd_defines.vh"
module dmsd_core #(
  parameter EXPANDED_ONCHIP_RAM_DEPTH = `DMSD_EXPANDED_ONCHIP_RAM_DEPTH
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire int_req_in,
  input wire int_we_in,
  input wire int_direct_in,
  input wire [7:0] int_addr_in,
  input wire [7:0] int_wdata_in,
  output reg [7:0] int_rdata_out,
  output reg sfr_sel_out,
  input wire [7:0] sfr_rdata_in,
  input wire xmov_req_in,
  input wire xmov_we_in,
  input wire xmov_use_ptr_in,
  input wire [7:0] bank_ptr_in,
  input wire [7:0] xmov_wdata_in,
  input wire code_move_in,
  output reg [7:0] xmov_rdata_out,
  output reg xmov_done_out,
  output reg [7:0] low_port_out,
  output reg low_port_oe_out,
  input wire [7:0] low_port_in,
  output reg [7:0] high_port_out,
  output reg write_strobe_n_out,
  output reg read_strobe_n_out,
  output wire latch_strobe_out,
  output reg offchip_xmem_select_out,
  output reg latch_strobe_suppress_out
);
  ////////////////////////////////////////////////////////////////////////////
  // External bus phases, one-hot; the strobe spans DATA and HOLD so that a
  // read value has time to pass both stages of the low-port synchroniser
  localparam ST_IDLE = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_DATA = 5'b00100;
  localparam ST_HOLD = 5'b01000;
  localparam ST_END = 5'b10000;

  reg [7:0] lower_ram [0:127];
  reg [7:0] upper_ram [0:127];
  reg [7:0] expanded_onchip_ram [0:EXPANDED_ONCHIP_RAM_DEPTH-1];
  reg [15:0] ptr0_ff;
  reg [15:0] ptr1_ff;
  reg ptr_sel_ff;
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [15:0] xaddr_ff;
  reg [7:0] xwdata_ff;
  reg xwe_ff;
  reg wide_ff;
  reg ext_busy;
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  wire [15:0] cur_ptr;
  wire [15:0] xaddr;
  wire expanded_onchip_ram_hit;
  wire low_hit;
  wire upper_hit;

  // Lower half is shared; above 7Fh the addressing mode picks the space
  function is_special;
    input [7:0] addr;
    input direct;
    begin
      is_special = (addr > `DMSD_LOWER_TOP) && direct;
    end
  endfunction

  // Replace one byte of a pointer; high selects the upper byte
  function [15:0] wr_byte;
    input [15:0] old;
    input high;
    input [7:0] data;
    begin
      wr_byte = high ? {data, old[7:0]} : {old[15:8], data};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Internal space decode
  // Owned special registers answer here; all other direct hits above 7Fh go outside
  assign low_hit = int_req_in && (int_addr_in <= `DMSD_LOWER_TOP);
  assign upper_hit = int_req_in && !int_direct_in && (int_addr_in > `DMSD_LOWER_TOP);
  wire sfr_hit = int_req_in && is_special(int_addr_in, int_direct_in);
  wire aux_hit = sfr_hit && (int_addr_in == `DMSD_AUX_CTRL_ADDR);
  wire aux2_hit = sfr_hit && (int_addr_in == `DMSD_SECOND_AUX_ADDR);
  wire p0l = sfr_hit && (int_addr_in == `DMSD_PTR0_LOW_ADDR);
  wire p0h = sfr_hit && (int_addr_in == `DMSD_PTR0_HIGH_ADDR);
  wire p1l = sfr_hit && (int_addr_in == `DMSD_PTR1_LOW_ADDR);
  wire p1h = sfr_hit && (int_addr_in == `DMSD_PTR1_HIGH_ADDR);
  wire own_sfr = aux_hit || aux2_hit || p0l || p0h || p1l || p1h;

  // RAM arrays hold no reset; only control state does
  // Software must not rely on RAM contents after power-up
  always @(posedge clk_in) begin
    if (low_hit && int_we_in) begin
      lower_ram[int_addr_in[6:0]] <= int_wdata_in;
    end
    if (upper_hit && int_we_in) begin
      upper_ram[int_addr_in[6:0]] <= int_wdata_in;
    end
    if (expanded_onchip_ram_hit && xmov_we_in) begin
      expanded_onchip_ram[xaddr[`DMSD_EXPANDED_ONCHIP_RAM_AW-1:0]] <= xmov_wdata_in;
    end
  end

  // Control registers and data pointers
  // Upper control bits are not stored, so ones written there are dropped
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      offchip_xmem_select_out <= 1'b0;
      latch_strobe_suppress_out <= 1'b0;
      ptr_sel_ff <= 1'b0;
      ptr0_ff <= 16'h0000;
      ptr1_ff <= 16'h0000;
    end else if (int_we_in) begin
      if (aux_hit) begin
        offchip_xmem_select_out <= int_wdata_in[`DMSD_OFFCHIP_BIT];
        latch_strobe_suppress_out <= int_wdata_in[`DMSD_SUPPRESS_BIT];
      end
      if (aux2_hit) begin
        ptr_sel_ff <= int_wdata_in[`DMSD_SELECTOR_BIT];
      end
      if (p0l || p0h) begin
        ptr0_ff <= wr_byte(ptr0_ff, p0h, int_wdata_in);
      end
      if (p1l || p1h) begin
        ptr1_ff <= wr_byte(ptr1_ff, p1h, int_wdata_in);
      end
    end
  end

  // Registered read mux; upper aux bits read zero here
  // Data stands until the next request, so a slow reader still sees it
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_rdata_out <= 8'h00;
      sfr_sel_out <= 1'b0;
    end else begin
      sfr_sel_out <= sfr_hit && !own_sfr;
      if (low_hit) begin
        int_rdata_out <= lower_ram[int_addr_in[6:0]];
      end else if (upper_hit) begin
        int_rdata_out <= upper_ram[int_addr_in[6:0]];
      end else if (aux_hit) begin
        int_rdata_out <= {6'h00, offchip_xmem_select_out, latch_strobe_suppress_out};
      end else if (aux2_hit) begin
        int_rdata_out <= {7'h00, ptr_sel_ff};
      end else if (p0l || p1l) begin
        int_rdata_out <= p0l ? ptr0_ff[7:0] : ptr1_ff[7:0];
      end else if (p0h || p1h) begin
        int_rdata_out <= p0h ? ptr0_ff[15:8] : ptr1_ff[15:8];
      end else if (sfr_hit) begin
        // Outside special registers answer through the same read path
        int_rdata_out <= sfr_rdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External move decode
  assign cur_ptr = ptr_sel_ff ? ptr1_ff : ptr0_ff;
  assign xaddr = xmov_use_ptr_in ? cur_ptr : {8'h00, bank_ptr_in};
  assign expanded_onchip_ram_hit = xmov_req_in && (state_ff == ST_IDLE) && !offchip_xmem_select_out
    && (xaddr <= `DMSD_EXPANDED_ONCHIP_RAM_TOP);
  // Whatever misses the on-chip RAM becomes a bus cycle; a request while
  // the sequencer is busy is dropped, the core never issues one
  wire ext_start = xmov_req_in && (state_ff == ST_IDLE) && !expanded_onchip_ram_hit;

  // Bus sequencer: address phase, strobe phase, release
  always @* begin
    nxt_state = state_ff;
    ext_busy = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (ext_start) begin
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        nxt_state = ST_DATA;
        ext_busy = 1'b1;
      end
      ST_DATA: begin
        nxt_state = ST_HOLD;
        ext_busy = 1'b1;
      end
      ST_HOLD: begin
        nxt_state = ST_END;
        ext_busy = 1'b1;
      end
      ST_END: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Low port input is off-chip: two stages before use
  // The cost is two cycles of read latency, absorbed by the HOLD phase
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= low_port_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Pin drive and capture
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      xaddr_ff <= 16'h0000;
      xwdata_ff <= 8'h00;
      xwe_ff <= 1'b0;
      wide_ff <= 1'b0;
      low_port_out <= 8'h00;
      low_port_oe_out <= 1'b0;
      high_port_out <= 8'h00;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      xmov_rdata_out <= 8'h00;
      xmov_done_out <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      xmov_done_out <= 1'b0;
      if (expanded_onchip_ram_hit) begin
        // Low port and strobes untouched; high port shows address
        high_port_out <= xaddr[15:8];
        xmov_rdata_out <= expanded_onchip_ram[xaddr[`DMSD_EXPANDED_ONCHIP_RAM_AW-1:0]];
        xmov_done_out <= 1'b1;
      end
      if (ext_start) begin
        xaddr_ff <= xaddr;
        xwdata_ff <= xmov_wdata_in;
        xwe_ff <= xmov_we_in;
        wide_ff <= xmov_use_ptr_in;
        low_port_out <= xaddr[7:0];
        low_port_oe_out <= 1'b1;
        if (xmov_use_ptr_in) begin
          high_port_out <= xaddr[15:8];
        end
      end
      if (state_ff == ST_ADDR) begin
        // Address has been latched; swap to data
        low_port_out <= xwdata_ff;
        low_port_oe_out <= xwe_ff;
        write_strobe_n_out <= !xwe_ff;
        read_strobe_n_out <= xwe_ff;
      end
      if (state_ff == ST_HOLD) begin
        // Strobe rises while data still drives the port, so the far side
        // latches a settled byte on a write
        write_strobe_n_out <= 1'b1;
        read_strobe_n_out <= 1'b1;
      end
      if (state_ff == ST_END) begin
        // On a write the port is released only after the strobe; done and read data coincide
        low_port_oe_out <= 1'b0;
        xmov_done_out <= 1'b1;
        if (!xwe_ff) begin
          xmov_rdata_out <= sync2_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch strobe: access-only mode pulses for external and code moves
  dmsd_latch_strobe u_strobe (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .suppress_in(latch_strobe_suppress_out),
    .ext_cycle_in(ext_start || code_move_in),
    .strobe_out(latch_strobe_out)
  );

  // Bus-busy marker kept for the sequencer; also sinks wide_ff and xaddr_ff
  wire unused_ok = ext_busy & wide_ff & xaddr_ff[0];
endmodule
`default_nettype wire

// [verification/dmsd_core_sva.sv]
// Checker for the data memory space decoder ports
`timescale 1ns/10ps
`default_nettype none
module dmsd_core_sva #(
  parameter EXPANDED_ONCHIP_RAM_DEPTH = 512
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic int_req_in,
  input wire logic int_we_in,
  input wire logic int_direct_in,
  input wire logic [7:0] int_addr_in,
  input wire logic [7:0] int_wdata_in,
  input wire logic sfr_sel_out,
  input wire logic xmov_req_in,
  input wire logic xmov_we_in,
  input wire logic xmov_use_ptr_in,
  input wire logic [7:0] bank_ptr_in,
  input wire logic [7:0] xmov_wdata_in,
  input wire logic code_move_in,
  input wire logic xmov_done_out,
  input wire logic [7:0] low_port_out,
  input wire logic low_port_oe_out,
  input wire logic write_strobe_n_out,
  input wire logic read_strobe_n_out,
  input wire logic latch_strobe_out,
  input wire logic offchip_xmem_select_out,
  input wire logic latch_strobe_suppress_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Requests only ever start while idle, so no busy tracking is kept here
  wire x_ext = xmov_req_in && offchip_xmem_select_out;
  wire x_onc = xmov_req_in && !xmov_use_ptr_in && !offchip_xmem_select_out;
  wire aux_wr = int_req_in && int_we_in && int_direct_in && int_addr_in == 8'h8E;
  a_strobe_excl: assert property (write_strobe_n_out || read_strobe_n_out)
    else $error("both strobes low");
  a_expanded_onchip_ram_quiet: assert property (
    x_onc |=> (write_strobe_n_out && read_strobe_n_out && !low_port_oe_out)[*4])
    else $error("bus moved on on-chip access");
  a_expanded_onchip_ram_done: assert property (x_onc |=> xmov_done_out)
    else $error("on-chip done late");
  a_ext_addr: assert property (
    x_ext && !xmov_use_ptr_in |=> low_port_oe_out && low_port_out == $past(bank_ptr_in))
    else $error("low port address wrong");
  a_ext_write: assert property (
    x_ext && xmov_we_in |-> ##2 !write_strobe_n_out && low_port_out == $past(xmov_wdata_in, 2))
    else $error("write cycle wrong");
  a_ext_read: assert property (x_ext && !xmov_we_in |-> ##2 !read_strobe_n_out && !low_port_oe_out)
    else $error("read cycle wrong");
  a_ext_done: assert property (x_ext |-> ##5 xmov_done_out)
    else $error("external done late");
  a_aux_write: assert property (
    aux_wr |=> offchip_xmem_select_out == $past(int_wdata_in[1])
    && latch_strobe_suppress_out == $past(int_wdata_in[0]))
    else $error("control bits not written");
  a_space_sel: assert property (
    int_req_in && int_addr_in == 8'hA0 |=> sfr_sel_out == $past(int_direct_in))
    else $error("space select wrong");
  a_free_latch: assert property (
    latch_strobe_out && !latch_strobe_suppress_out |=>
    (!latch_strobe_out || latch_strobe_suppress_out)[*5] ##1 (latch_strobe_out || latch_strobe_suppress_out))
    else $error("latch rate wrong");
  a_code_latch: assert property (latch_strobe_suppress_out && code_move_in |=> latch_strobe_out)
    else $error("no latch on code move");
endmodule
bind dmsd_core dmsd_core_sva #(.EXPANDED_ONCHIP_RAM_DEPTH(EXPANDED_ONCHIP_RAM_DEPTH)) u_sva (.clk_in, .rst_n_in, .int_req_in, .int_we_in,
  .int_direct_in, .int_addr_in, .int_wdata_in, .sfr_sel_out, .xmov_req_in, .xmov_we_in, .xmov_use_ptr_in,
  .bank_ptr_in, .xmov_wdata_in, .code_move_in, .xmov_done_out, .low_port_out, .low_port_oe_out,
  .write_strobe_n_out, .read_strobe_n_out, .latch_strobe_out, .offchip_xmem_select_out,
  .latch_strobe_suppress_out);
`default_nettype wire

// [verification/dmsd_ext_mem.sv]
// External data memory on the multiplexed low port
`timescale 1ns/10ps
`default_nettype none
module dmsd_ext_mem (
  input wire logic clk_in,
  input wire logic [7:0] low_port_out,
  input wire logic low_port_oe_out,
  input wire logic [7:0] high_port_out,
  input wire logic write_strobe_n_out,
  input wire logic read_strobe_n_out,
  output logic [7:0] low_port_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_ff;
  logic oe_ff = 1'b0;
  logic [7:0] last_ff = 8'h00;
  // Address taken as the low port starts driving; later driven bytes are data
  always @(posedge clk_in) begin
    oe_ff <= low_port_oe_out;
    if (low_port_oe_out && !oe_ff)
      addr_ff <= {high_port_out, low_port_out};
    if (!write_strobe_n_out)
      mem[addr_ff] <= low_port_out;
    if (!read_strobe_n_out)
      last_ff <= low_port_in;
  end
  // Released bus shows inverted data so a stale capture cannot pass
  always @* begin
    if (read_strobe_n_out)
      low_port_in = ~last_ff;
    else
      low_port_in = mem[addr_ff];
  end
endmodule
`default_nettype wire

// [verification/test_data_memory_space_decode.sv]
// Self-checking bench for the data memory space decoder
`timescale 1ns/10ps
`default_nettype none
module test_data_memory_space_decode;
  logic clk_in, rst_n_in, ireq, iwe, idir, xreq, xwe, xptr, cmove;
  logic [7:0] iaddr, iwd, bptr, xwd, v;
  logic [7:0] srd = 8'h96;
  wire [7:0] ird, xrd, lpo, lpi, hpo;
  wire ssel, xdone, lpoe, wr_n, rd_n, ls, xsel, xsup;
  int err_count, samples_checked, n;
  dmsd_core DUT (.clk_in, .rst_n_in, .int_req_in(ireq), .int_we_in(iwe), .int_direct_in(idir),
    .int_addr_in(iaddr), .int_wdata_in(iwd), .int_rdata_out(ird), .sfr_sel_out(ssel), .sfr_rdata_in(srd),
    .xmov_req_in(xreq), .xmov_we_in(xwe), .xmov_use_ptr_in(xptr), .bank_ptr_in(bptr), .xmov_wdata_in(xwd),
    .code_move_in(cmove), .xmov_rdata_out(xrd), .xmov_done_out(xdone), .low_port_out(lpo),
    .low_port_oe_out(lpoe), .low_port_in(lpi), .high_port_out(hpo), .write_strobe_n_out(wr_n),
    .read_strobe_n_out(rd_n), .latch_strobe_out(ls), .offchip_xmem_select_out(xsel),
    .latch_strobe_suppress_out(xsup));
  dmsd_ext_mem MEM (.clk_in, .low_port_out(lpo), .low_port_oe_out(lpoe), .high_port_out(hpo),
    .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n), .low_port_in(lpi));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  // Internal access: answer registered at the taking edge
  task automatic ia(input logic we, dir, input logic [7:0] a, d);
    @(posedge clk_in);
    ireq <= 1'b1;
    iwe <= we;
    idir <= dir;
    iaddr <= a;
    iwd <= d;
    @(posedge clk_in);
    ireq <= 1'b0;
    #1;
  endtask
  // External move, waits on the done pulse with a bound
  task automatic xm(input logic we, ptr, input logic [7:0] bp, d);
    @(posedge clk_in);
    xreq <= 1'b1;
    xwe <= we;
    xptr <= ptr;
    bptr <= bp;
    xwd <= d;
    @(posedge clk_in);
    xreq <= 1'b0;
    #1;
    n = 0;
    while (xdone !== 1'b1 && n < 12) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("done", 8'h01, {7'h00, xdone});
  endtask
  task automatic cnt(output logic [7:0] c);
    c = 8'h00;
    repeat (60) begin
      c += {7'h00, ls};
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Watchdog well past the expected run of some 280 cycles
  initial begin
    #300000;
    err_count++;
    final_report;
  end
  initial begin
    {rst_n_in, ireq, iwe, idir, xreq, xwe, xptr, cmove} = 8'h00;
    {iaddr, iwd, bptr, xwd} = 32'h0000_0000;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    ia(0, 1, 8'h8E, 8'h00);
    chk("aux", 8'h00, ird);
    chk("latch mode", 8'h00, {7'h00, xsup});
    ia(1, 1, 8'h7F, 8'h3C);
    ia(0, 0, 8'h7F, 8'h00);
    chk("lower", 8'h3C, ird);
    ia(1, 0, 8'hA0, 8'hC3);
    ia(0, 0, 8'hA0, 8'h00);
    chk("upper", 8'hC3, ird);
    ia(0, 1, 8'hA0, 8'h00);
    chk("special", 8'h01, {7'h00, ssel});
    chk("special data", 8'h96, ird);
    $display("test internal done");
    xm(1, 0, 8'hA0, 8'h5A);
    xm(0, 0, 8'hA0, 8'h00);
    chk("expanded_onchip_ram", 8'h5A, xrd);
    ia(1, 1, 8'h82, 8'hFF);
    ia(1, 1, 8'h83, 8'h01);
    xm(1, 1, 8'h00, 8'h77);
    xm(0, 1, 8'h00, 8'h00);
    chk("expanded_onchip_ram top", 8'h77, xrd);
    chk("high", 8'h01, hpo);
    ia(1, 1, 8'h82, 8'h00);
    ia(1, 1, 8'h83, 8'h02);
    xm(1, 1, 8'h00, 8'h24);
    ia(1, 1, 8'hA2, 8'h01);
    ia(1, 1, 8'h84, 8'h00);
    ia(1, 1, 8'h85, 8'h03);
    xm(1, 1, 8'h00, 8'h81);
    ia(1, 1, 8'hA2, 8'h00);
    xm(0, 1, 8'h00, 8'h00);
    chk("ext ptr0", 8'h24, xrd);
    chk("high", 8'h02, hpo);
    ia(1, 1, 8'hA2, 8'h01);
    xm(0, 1, 8'h00, 8'h00);
    chk("ext ptr1", 8'h81, xrd);
    $display("test expanded done");
    ia(1, 1, 8'h8E, 8'h02);
    chk("offchip", 8'h01, {7'h00, xsel});
    xm(1, 0, 8'hA0, 8'h3E);
    xm(0, 0, 8'hA0, 8'h00);
    chk("paged", 8'h3E, xrd);
    ia(1, 1, 8'h8E, 8'h00);
    xm(0, 0, 8'hA0, 8'h00);
    chk("expanded_onchip_ram kept", 8'h5A, xrd);
    $display("test offchip done");
    cnt(v);
    chk("free latch", 8'h0A, v);
    ia(1, 1, 8'h8E, 8'h01);
    @(posedge clk_in);
    #1;
    cnt(v);
    chk("quiet latch", 8'h00, v);
    @(posedge clk_in);
    cmove <= 1'b1;
    @(posedge clk_in);
    cmove <= 1'b0;
    #1;
    cnt(v);
    chk("code latch", 8'h01, v);
    $display("test latch done");
    final_report;
  end
endmodule
`default_nettype wire
